// ---- multi_match_pwm_timer.sv ----
// Timer/counter with seven match registers and six PWM outputs
`default_nettype none
// How it works
// - Counter ticks from the clock, or from a chosen capture input edge.
// - Seven match registers drive six outputs, each single- or double-edge, except output 0, which is single-edge only.
// - Cycle match register resets the count and marks each period.
// - Single-edge outputs rise at cycle start, fall at their own match.
// - Single-edge output with match value zero stays low all cycle.
// - Double-edge output rises on one match, falls on the next one.
// - Both double-edge positions may sit anywhere inside the cycle.
// - Each match may continue, stop or reset the counter, optionally interrupting.
// - New PWM match values take effect only at a cycle boundary once released; timer mode applies them at once.
// - Period and widths are whole tick counts; one shared repetition rate.
// - With PWM off it is a plain 32-bit timer with 32-bit prescaler.
module multi_match_pwm_timer
    import pwm_timer_pkg::*;
(
    // Clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            reset_i,
    // Register port
    input  wire bus_req_t        bus_i,
    output logic [DW-1:0]        rdata_o,
    // Capture pins
    input  wire logic [NCAP-1:0] cap_i,
    // Outputs
    output logic [NOUT-1:0]      pwm_o,
    output logic                 irq_o
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [NMATCH-1:0] match_vec(
        input logic [DW-1:0]             c,
        input logic [NMATCH-1:0][DW-1:0] m
    );
        logic [NMATCH-1:0] v;
        v = '0;
        for (int i = 0; i < NMATCH; i++) begin
            v[i] = (c == m[i]);
        end
        return v;
    endfunction : match_vec

    function automatic logic [NMATCH-1:0] mctl_field(
        input logic [NMATCH*MCTL_W-1:0] ctl,
        input int                       pos
    );
        logic [NMATCH-1:0] v;
        v = '0;
        for (int i = 0; i < NMATCH; i++) begin
            v[i] = ctl[i*MCTL_W+pos];
        end
        return v;
    endfunction : mctl_field

    function automatic logic is_match_addr(input logic [AW-1:0] a);
        logic [AW-1:0] off;
        off = a - A_MATCH0;
        return (off[WORD_B-1:0] == '0) && ((off >> WORD_B) < AW'(NMATCH));
    endfunction : is_match_addr

    function automatic logic [MIDX_W-1:0] match_idx(input logic [AW-1:0] a);
        logic [AW-1:0] off;
        off = a - A_MATCH0;
        return off[WORD_B +: MIDX_W];
    endfunction : match_idx

    // ************************************************************
    // Count events and match detection
    // ************************************************************
    state_t            s_r;
    state_t            s_nxt;
    logic              cap_rise;
    logic              cap_fall;
    logic              src_evt;
    logic              cnt_evt;
    logic              tick;
    logic              cyc;
    logic [NMATCH-1:0] hit;
    logic [NMATCH-1:0] rst_v;
    logic [NMATCH-1:0] stop_v;
    logic [NMATCH-1:0] int_v;
    logic [NMATCH-1:0] w1c;

    assign cap_rise = s_r.cap_s2[s_r.cap_sel] & ~s_r.cap_prev[s_r.cap_sel];
    assign cap_fall = ~s_r.cap_s2[s_r.cap_sel] & s_r.cap_prev[s_r.cap_sel];

    always_comb begin
        unique case (s_r.src)
            SRC_CLK:  src_evt = 1'b1;
            SRC_RISE: src_evt = cap_rise;
            SRC_FALL: src_evt = cap_fall;
            SRC_BOTH: src_evt = cap_rise | cap_fall;
        endcase
    end

    assign cnt_evt = src_evt && s_r.run && !s_r.clr;
    assign tick    = cnt_evt && (s_r.pcnt == s_r.pre);
    assign hit     = tick ? match_vec(s_r.count, s_r.act) : '0;
    assign cyc     = s_r.pwm_en && hit[0];
    // In PWM mode the cycle match always resets, whatever its control bits
    assign rst_v   = mctl_field(s_r.mctl, MCTL_RST) | NMATCH'(s_r.pwm_en);
    assign stop_v  = mctl_field(s_r.mctl, MCTL_STOP);
    assign int_v   = mctl_field(s_r.mctl, MCTL_INT);
    assign w1c     = (bus_i.wr && bus_i.addr == A_INTSTAT) ? bus_i.wdata[NMATCH-1:0] : '0;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_nxt          = s_r;
        s_nxt.cap_s1   = cap_i;
        s_nxt.cap_s2   = s_r.cap_s1;
        s_nxt.cap_prev = s_r.cap_s2;

        if (s_r.clr) begin
            s_nxt.pcnt  = '0;
            s_nxt.count = '0;
        end else if (cnt_evt) begin
            if (tick) begin
                s_nxt.pcnt = '0;
                if (|(hit & rst_v)) begin
                    s_nxt.count = '0;
                end else begin
                    s_nxt.count = s_r.count + DW'(1);
                end
                if (|(hit & stop_v)) begin
                    s_nxt.run = 1'b0;
                end
            end else begin
                s_nxt.pcnt = s_r.pcnt + DW'(1);
            end
        end

        // Set beats a same-cycle clear so no match is lost
        s_nxt.stat = (s_r.stat & ~w1c) | (hit & int_v);

        // Timer mode has no pulses to tear, so values apply at once
        if (!s_r.pwm_en) begin
            s_nxt.act = s_r.shd;
        end else if (cyc) begin
            for (int i = 0; i < NMATCH; i++) begin
                if (s_r.rel[i]) begin
                    s_nxt.act[i] = s_r.shd[i];
                    s_nxt.rel[i] = 1'b0;
                end
            end
        end

        for (int k = 0; k < NOUT; k++) begin
            if (!s_r.pwm_en || !s_r.oen[k]) begin
                s_nxt.pwm[k] = 1'b0;
            end else if (s_r.dbl[k] && k != 0) begin
                // Fall wins when both edges share one count
                if (hit[k+1]) begin
                    s_nxt.pwm[k] = 1'b0;
                end else if (hit[k]) begin
                    s_nxt.pwm[k] = 1'b1;
                end
            end else begin
                if (hit[k+1]) begin
                    s_nxt.pwm[k] = 1'b0;
                end else if (cyc && s_nxt.act[k+1] != '0) begin
                    s_nxt.pwm[k] = 1'b1;
                end
            end
        end

        if (bus_i.wr) begin
            case (bus_i.addr)
                A_CTRL: begin
                    s_nxt.run    = bus_i.wdata[CTRL_RUN];
                    s_nxt.clr    = bus_i.wdata[CTRL_CLR];
                    s_nxt.pwm_en = bus_i.wdata[CTRL_PWM];
                end
                A_PRE:      s_nxt.pre  = bus_i.wdata;
                A_MODE: begin
                    s_nxt.src     = src_t'(bus_i.wdata[MODE_SRC +: 2]);
                    s_nxt.cap_sel = bus_i.wdata[MODE_SEL];
                end
                A_MATCHCTL: s_nxt.mctl = bus_i.wdata[NMATCH*MCTL_W-1:0];
                A_RELEASE:  s_nxt.rel  = s_r.rel | bus_i.wdata[NMATCH-1:0];
                A_OUTCTL: begin
                    s_nxt.dbl = bus_i.wdata[OUT_DBL +: NOUT];
                    s_nxt.oen = bus_i.wdata[OUT_EN +: NOUT];
                end
                A_INTMASK:  s_nxt.mask = bus_i.wdata[NMATCH-1:0];
                default: begin
                    if (is_match_addr(bus_i.addr)) begin
                        s_nxt.shd[match_idx(bus_i.addr)] = bus_i.wdata;
                    end
                end
            endcase
        end

        s_nxt.irq   = |(s_nxt.stat & s_nxt.mask);
        s_nxt.rdata = '0;
        if (bus_i.rd) begin
            case (bus_i.addr)
                A_CTRL:     s_nxt.rdata = DW'({s_r.pwm_en, s_r.clr, s_r.run});
                A_COUNT:    s_nxt.rdata = s_r.count;
                A_PRE:      s_nxt.rdata = s_r.pre;
                A_PRECNT:   s_nxt.rdata = s_r.pcnt;
                A_MODE:     s_nxt.rdata = DW'({s_r.cap_sel, s_r.src});
                A_MATCHCTL: s_nxt.rdata = DW'(s_r.mctl);
                A_RELEASE:  s_nxt.rdata = DW'(s_r.rel);
                A_OUTCTL:   s_nxt.rdata = (DW'(s_r.oen) << OUT_EN) | DW'(s_r.dbl);
                A_INTSTAT:  s_nxt.rdata = DW'(s_r.stat);
                A_INTMASK:  s_nxt.rdata = DW'(s_r.mask);
                default: begin
                    if (is_match_addr(bus_i.addr)) begin
                        s_nxt.rdata = s_r.shd[match_idx(bus_i.addr)];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o = s_r.rdata;
    assign pwm_o   = s_r.pwm;
    assign irq_o   = s_r.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_cycle_end;
        tick && s_r.pwm_en && s_r.count == s_r.act[0];
    endsequence

    property p_cycle_reset;
        s_cycle_end |=> s_r.count == '0 || s_r.clr;
    endproperty
    a_cycle_reset: assert property (p_cycle_reset)
        else $error("count not reset at cycle match");

    property p_count_step;
        (tick && !(|(hit & rst_v)) && !bus_i.wr) |=> s_r.count == $past(s_r.count) + DW'(1);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("count did not advance on tick");

    property p_stop;
        (|(hit & stop_v) && !bus_i.wr) |=> !s_r.run ##1 $stable(s_r.count);
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter kept running after stop match");

    property p_flag_set;
        |(hit & int_v) |=> ((($past(hit) & $past(int_v)) & ~s_r.stat) == '0);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("match flag not set");

    property p_rise;
        (s_cycle_end and (!hit[1] && s_r.oen[0])) |=> s_r.pwm[0] == (s_r.act[1] != '0);
    endproperty
    a_rise: assert property (p_rise)
        else $error("single-edge output did not rise at cycle start");

    property p_const_low;
        (s_r.pwm_en && !s_r.pwm[4] && s_r.act[5] == '0) |=> !s_r.pwm[4] || s_r.act[5] != '0;
    endproperty
    a_const_low: assert property (p_const_low)
        else $error("constant-low output rose");

    property p_fall;
        (tick && s_r.pwm_en && hit[1]) |=> !s_r.pwm[0];
    endproperty
    a_fall: assert property (p_fall)
        else $error("single-edge output did not fall at its match");

    property p_double;
        (s_r.pwm_en && s_r.dbl[2] && s_r.oen[2] && hit[2] && !hit[3] && !bus_i.wr)
            |=> s_r.pwm[2];
    endproperty
    a_double: assert property (p_double)
        else $error("double-edge output did not rise");

    property p_hold;
        (s_r.pwm_en && !(tick && s_r.count == s_r.act[0]) && !bus_i.wr)
            |=> $stable(s_r.act);
    endproperty
    a_hold: assert property (p_hold)
        else $error("match values changed inside a cycle");

endmodule : multi_match_pwm_timer
`default_nettype wire

// ---- pwm_timer_pkg.sv ----
// Constants, register map and state layout of the multi-match PWM timer
`default_nettype none
package pwm_timer_pkg;
    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NMATCH = 7;
    localparam int NOUT   = 6;
    localparam int NCAP   = 2;
    localparam int AW     = 8;
    localparam int DW     = 32;
    localparam int MIDX_W = 3;
    localparam int WORD_B = 2;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [AW-1:0] A_CTRL     = 8'h00;
    localparam logic [AW-1:0] A_COUNT    = 8'h04;
    localparam logic [AW-1:0] A_PRE      = 8'h08;
    localparam logic [AW-1:0] A_PRECNT   = 8'h0C;
    localparam logic [AW-1:0] A_MODE     = 8'h10;
    localparam logic [AW-1:0] A_MATCHCTL = 8'h14;
    localparam logic [AW-1:0] A_RELEASE  = 8'h18;
    localparam logic [AW-1:0] A_OUTCTL   = 8'h1C;
    localparam logic [AW-1:0] A_INTSTAT  = 8'h20;
    localparam logic [AW-1:0] A_INTMASK  = 8'h24;
    localparam logic [AW-1:0] A_MATCH0   = 8'h40;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_CLR   = 1;
    localparam int CTRL_PWM   = 2;
    localparam int MODE_SRC   = 0;
    localparam int MODE_SEL   = 2;
    localparam int MCTL_INT   = 0;
    localparam int MCTL_RST   = 1;
    localparam int MCTL_STOP  = 2;
    localparam int MCTL_W     = 3;
    localparam int OUT_DBL    = 0;
    localparam int OUT_EN     = 8;

    typedef enum logic [1:0] {SRC_CLK, SRC_RISE, SRC_FALL, SRC_BOTH} src_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } bus_req_t;

    typedef struct packed {
        logic [NCAP-1:0]              cap_s1;
        logic [NCAP-1:0]              cap_s2;
        logic [NCAP-1:0]              cap_prev;
        logic                         run;
        logic                         clr;
        logic                         pwm_en;
        src_t                         src;
        logic                         cap_sel;
        logic [NMATCH*MCTL_W-1:0]     mctl;
        logic [NMATCH-1:0]            rel;
        logic [NOUT-1:0]              dbl;
        logic [NOUT-1:0]              oen;
        logic [NMATCH-1:0]            stat;
        logic [NMATCH-1:0]            mask;
        logic [DW-1:0]                pre;
        logic [DW-1:0]                pcnt;
        logic [DW-1:0]                count;
        logic [NMATCH-1:0][DW-1:0]    shd;
        logic [NMATCH-1:0][DW-1:0]    act;
        logic [NOUT-1:0]              pwm;
        logic                         irq;
        logic [DW-1:0]                rdata;
    } state_t;

    localparam state_t STATE_RST = '0;
endpackage : pwm_timer_pkg
`default_nettype wire

// ---- pwm_load.sv ----
// Behavioural load on the PWM outputs: measures pulse width and period
`default_nettype none
module pwm_load
    import pwm_timer_pkg::*;
(
    // Clock
    input  wire logic                  ref_clk_i,
    // Outputs of the timer
    input  wire logic [NOUT-1:0]       pwm_i,
    // Last complete measurement per output, in clock cycles
    output logic [NOUT-1:0][15:0]      high_o,
    output logic [NOUT-1:0][15:0]      period_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [NOUT-1:0][15:0] hcnt_r = '0;
    logic [NOUT-1:0][15:0] pcnt_r = '0;
    logic [NOUT-1:0][15:0] high_r = '0;
    logic [NOUT-1:0][15:0] per_r  = '0;
    logic [NOUT-1:0]       last_r = '0;

    assign high_o   = high_r;
    assign period_o = per_r;

    // Rise to rise gives the period; rise to fall the high time
    always @(posedge ref_clk_i) begin
        for (int k = 0; k < NOUT; k++) begin
            last_r[k] <= pwm_i[k];
            if (pwm_i[k] && !last_r[k]) begin
                per_r[k]    <= pcnt_r[k] + 16'h0001;
                pcnt_r[k]   <= 16'h0000;
                hcnt_r[k]   <= 16'h0001;
            end else begin
                pcnt_r[k] <= pcnt_r[k] + 16'h0001;
                if (pwm_i[k]) begin
                    hcnt_r[k] <= hcnt_r[k] + 16'h0001;
                end
            end
            if (!pwm_i[k] && last_r[k]) begin
                high_r[k] <= hcnt_r[k];
            end
        end
    end
endmodule : pwm_load
`default_nettype wire

// ---- multi_match_pwm_timer_tb_top.sv ----
// Self-checking testbench of the multi-match PWM timer
`default_nettype none
module multi_match_pwm_timer_tb_top import pwm_timer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  ref_clk = 1'b0;
    logic                  reset;
    bus_req_t              bus;
    logic [DW-1:0]         rdata;
    logic [NCAP-1:0]       cap;
    logic [NOUT-1:0]       pwm;
    logic                  irq;
    logic [NOUT-1:0][15:0] high;
    logic [NOUT-1:0][15:0] period;
    logic                  lo_seen;
    logic [DW-1:0]         va;
    logic [DW-1:0]         vb;
    int                    bad_count = 0;
    int                    samples_checked = 0;
    int                    cycles = 0;

    multi_match_pwm_timer i_dut (.ref_clk_i(ref_clk), .reset_i(reset), .bus_i(bus),
        .rdata_o(rdata), .cap_i(cap), .pwm_o(pwm), .irq_o(irq));
    pwm_load i_load (.ref_clk_i(ref_clk), .pwm_i(pwm), .high_o(high), .period_o(period));

    always #4 ref_clk = ~ref_clk;

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Whole run needs some 540 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1 d = rdata;
    endtask : rd

    task automatic rchk(input string what, input logic [AW-1:0] a, input logic [DW-1:0] exp);
        logic [DW-1:0] v;
        rd(a, v);
        chk(what, v, exp);
    endtask : rchk

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            lo_seen |= pwm[4];
        end
    endtask : idle

    task automatic pulse(input logic [NCAP-1:0] m, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            cap <= m;
            idle(4);
            @(posedge ref_clk);
            cap <= '0;
            idle(4);
        end
    endtask : pulse

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_prescale();
        wr(A_PRE, 32'h0000_0002);
        wr(A_CTRL, 32'h0000_0001);
        idle(10);
        rd(A_COUNT, va);
        repeat (28) @(posedge ref_clk);
        rd(A_COUNT, vb);
        chk("ticks in 30 cycles", vb - va, 32'h0000_000A);
        wr(A_CTRL, 32'h0000_0002);
        wr(A_PRE, 32'h0000_0000);
    endtask : t_prescale

    task automatic t_irq();
        wr(A_MATCH0 + 8'h04, 32'h0000_0004);
        wr(A_MATCHCTL, 32'h0000_0018);
        wr(A_INTMASK, 32'h0000_0002);
        wr(A_CTRL, 32'h0000_0001);
        idle(20);
        chk("irq raised", {31'h0, irq}, 32'h1);
        rd(A_COUNT, va);
        chk("count below reset match", {31'h0, va < 32'h5}, 32'h1);
        wr(A_INTMASK, 32'h0000_0000);
        idle(2);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(A_CTRL, 32'h0000_0000);
        rchk("sticky flag", A_INTSTAT, 32'h0000_0002);
        wr(A_INTSTAT, 32'h0000_0002);
        rchk("flag cleared", A_INTSTAT, 32'h0000_0000);
    endtask : t_irq

    task automatic t_stop();
        wr(A_CTRL, 32'h0000_0002);
        wr(A_MATCHCTL, 32'h0000_0020);
        wr(A_CTRL, 32'h0000_0001);
        idle(20);
        rchk("run cleared", A_CTRL, 32'h0000_0000);
        rchk("count held", A_COUNT, 32'h0000_0005);
        rchk("unmapped", 8'hFC, 32'h0000_0000);
    endtask : t_stop

    task automatic t_counter();
        wr(A_CTRL, 32'h0000_0002);
        wr(A_MATCHCTL, 32'h0000_0000);
        wr(A_MODE, 32'h0000_0001);
        wr(A_CTRL, 32'h0000_0001);
        pulse(2'h2, 3);
        pulse(2'h1, 5);
        idle(8);
        rchk("edges counted", A_COUNT, 32'h0000_0005);
        wr(A_CTRL, 32'h0000_0002);
        wr(A_MODE, 32'h0000_0006);
        wr(A_CTRL, 32'h0000_0001);
        pulse(2'h1, 2);
        pulse(2'h2, 3);
        idle(8);
        rchk("falling edges", A_COUNT, 32'h0000_0003);
        wr(A_CTRL, 32'h0000_0002);
        wr(A_MODE, 32'h0000_0007);
        wr(A_CTRL, 32'h0000_0001);
        pulse(2'h2, 2);
        idle(8);
        rchk("both edges", A_COUNT, 32'h0000_0004);
        wr(A_MODE, 32'h0000_0000);
    endtask : t_counter

    task automatic t_pwm();
        wr(A_CTRL, 32'h0000_0006);
        wr(A_MATCH0, 32'h0000_0009);
        wr(A_MATCH0 + 8'h04, 32'h0000_0003);
        wr(A_MATCH0 + 8'h08, 32'h0000_0002);
        wr(A_MATCH0 + 8'h0C, 32'h0000_0006);
        wr(A_MATCH0 + 8'h14, 32'h0000_0000);
        wr(A_OUTCTL, 32'h0000_1504);
        wr(A_RELEASE, 32'h0000_002F);
        wr(A_CTRL, 32'h0000_0005);
        lo_seen = 1'b0;
        idle(60);
        chk("single period", 32'(period[0]), 32'h0000_000A);
        chk("single high", 32'(high[0]), 32'h0000_0004);
        chk("double period", 32'(period[2]), 32'h0000_000A);
        chk("double positive", 32'(high[2]), 32'h0000_0004);
        chk("constant low", {31'h0, lo_seen}, 32'h0);
        wr(A_MATCH0 + 8'h08, 32'h0000_0007);
        wr(A_MATCH0 + 8'h0C, 32'h0000_0002);
        wr(A_RELEASE, 32'h0000_000C);
        idle(40);
        chk("double negative", 32'(high[2]), 32'h0000_0005);
    endtask : t_pwm

    task automatic t_release();
        wr(A_MATCH0 + 8'h04, 32'h0000_0005);
        idle(40);
        chk("unreleased kept", 32'(high[0]), 32'h0000_0004);
        wr(A_RELEASE, 32'h0000_0002);
        idle(40);
        chk("released width", 32'(high[0]), 32'h0000_0006);
        rchk("release applied", A_RELEASE, 32'h0000_0000);
    endtask : t_release

    initial begin
        reset   = 1'b1;
        bus     = '0;
        cap     = '0;
        lo_seen = 1'b0;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        t_prescale();
        t_irq();
        t_stop();
        t_counter();
        t_pwm();
        t_release();
        report_and_stop();
    end
endmodule : multi_match_pwm_timer_tb_top
`default_nettype wire
